// ---- src/flash_erase_device.sv ----
// Behaviour
// (R1) block erase clears eight consecutive pages
// (R2) standard block: dummy, page bits 12..3, dummies
// (R3) binary block: two dummies, bits 21..12, dummies
// (R4) ten bits give block 0..1023, low ignored
// (R5) chip select rise starts timed block erase
// (R6) busy flag shown during any erase
// (R7) byte erase failure sets error flag
// (R8) sixty-four sectors, one per sector erase
// (R9) standard sub-sector 0a/0b by page bit 3
// (R10) standard sectors 1..63 from page bits 12..7
// (R11) binary sub-sector 0a/0b by bit 12
// (R12) binary sectors 1..63 from bits 21..16
// (R13) any address in sector; timed sector erase
// (R14) chip erase needs C7 94 80 9A
// (R15) chip erase: no address, extra bits dropped
// (R16) chip select rise starts timed chip erase
// (R17) chip erase skips protected or locked sectors
// (R18) write protect waits for chip erase end
// (R19) erased bytes read back as all ones
// (R20) ready returns after erase, error or not
// (R21) host polls ready before next command
module flash_erase_device #(
  parameter int BLOCK_CYCLES  = flash_erase_pkg::BLOCK_ERASE_CYCLES,
  parameter int SECTOR_CYCLES = flash_erase_pkg::SECTOR_ERASE_CYCLES,
  parameter int CHIP_CYCLES   = flash_erase_pkg::CHIP_ERASE_CYCLES
) (
  // clock and reset
  input  wire logic                        mclk_in,
  input  wire logic                        sys_rst_in,
  // serial link
  flash_link_if.device                     link,
  // configuration and protection
  input  wire logic                        binary_mode_in,
  input  wire logic [63:0]                 sector_protect_in,
  input  wire logic [63:0]                 sector_lock_in,
  input  wire logic                        write_protect_in,
  // array feedback
  input  wire logic                        erase_fail_in,
  // status
  output logic                             ready_out,
  output logic                             erase_program_error_flag_out,
  output logic                             hw_protect_out,
  // erase command to the array
  output logic                             erase_start_out,
  output flash_erase_pkg::erase_kind_t     erase_kind_out,
  output logic [9:0]                       erase_block_out,
  output logic [5:0]                       erase_sector_out,
  output logic                             erase_sub_b_out,
  output logic [63:0]                      erase_sector_mask_out,
  output logic [7:0]                       erased_fill_out
);
  import flash_erase_pkg::*;

  typedef enum logic {
    ST_IDLE,
    ST_ERASE
  } seq_state_t;

  // block field of the address, per page mode
  function automatic logic [9:0] block_field(input logic [23:0] addr, input logic binary);
    block_field = binary ? addr[BIN_BLOCK_LSB +: BLOCK_BITS] : addr[STD_BLOCK_LSB +: BLOCK_BITS];
  endfunction

  // expected chip erase byte by position
  function automatic logic [7:0] chip_byte(input logic [2:0] idx);
    case (idx)
      3'h0:    chip_byte = CHIP_SEQ_0;
      3'h1:    chip_byte = CHIP_SEQ_1;
      3'h2:    chip_byte = CHIP_SEQ_2;
      default: chip_byte = CHIP_SEQ_3;
    endcase
  endfunction

  // erase duration by kind, loaded as count minus one
  function automatic logic [31:0] erase_len(input erase_kind_t kind);
    case (kind)
      KIND_BLOCK:  erase_len = 32'(BLOCK_CYCLES - 1);
      KIND_SECTOR: erase_len = 32'(SECTOR_CYCLES - 1);
      default:     erase_len = 32'(CHIP_CYCLES - 1);
    endcase
  endfunction

  logic [3:0]  raw_pins;
  logic [2:0]  sync_q [4];
  logic [3:0]  filt;
  logic [3:0]  filt_prev;
  logic        sck_rise;
  logic        cs_fall;
  logic        cs_rise;
  logic        cs_active;
  logic        si_bit;
  logic [7:0]  shift_q;
  logic [7:0]  next_byte;
  logic [2:0]  bit_cnt;
  logic [2:0]  byte_cnt;
  logic [7:0]  opcode;
  logic [23:0] addr_q;
  logic        chip_ok;
  logic        frame_whole;
  logic        byte_done;
  logic        take_bit;
  logic [9:0]  blk_num;
  logic [5:0]  sec_num;
  logic        sub_b;
  erase_kind_t start_kind;
  logic        go;
  seq_state_t  state;
  erase_kind_t kind_q;
  logic [31:0] timer;
  logic        erase_err;
  logic        chip_busy;

  assign raw_pins = {write_protect_in, link.sck, link.cs_n, link.si};

  // three-stage synchronisers; a change counts once stages two and three agree
  generate
    for (genvar i = 0; i < 4; i++) begin : g_sync
      always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          sync_q[i] <= {3{SYNC_RST[i]}};
          filt[i]   <= SYNC_RST[i];
        end else begin
          sync_q[i] <= {sync_q[i][1:0], raw_pins[i]};
          if (sync_q[i][1] == sync_q[i][2]) begin
            filt[i] <= sync_q[i][2];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      filt_prev <= SYNC_RST;
    end else begin
      filt_prev <= filt;
    end
  end

  // link edge detection on the filtered levels
  assign sck_rise  = filt[2] & ~filt_prev[2];
  assign cs_fall   = ~filt[1] & filt_prev[1];
  assign cs_rise   = filt[1] & ~filt_prev[1];
  assign cs_active = ~filt[1];
  assign si_bit    = filt[0];
  assign next_byte = {shift_q[6:0], si_bit};
  assign byte_done = (bit_cnt == 3'h7);
  // once four bytes are in, further bits are dropped
  assign take_bit  = sck_rise & cs_active & (byte_cnt < FRAME_BYTES);   // see (R15)

  // byte assembly: opcode, then three address bytes; chip sequence tracked alongside
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      shift_q  <= 8'h00;
      bit_cnt  <= 3'h0;
      byte_cnt <= 3'h0;
      opcode   <= 8'h00;
      addr_q   <= 24'h000000;
      chip_ok  <= 1'b0;
    end else if (cs_fall) begin
      bit_cnt  <= 3'h0;
      byte_cnt <= 3'h0;
      chip_ok  <= 1'b0;
    end else if (take_bit) begin
      shift_q <= next_byte;
      bit_cnt <= bit_cnt + 3'h1;
      if (byte_done) begin
        byte_cnt <= byte_cnt + 3'h1;
        if (byte_cnt == 3'h0) begin
          opcode <= next_byte;
        end else begin
          addr_q <= {addr_q[15:0], next_byte};
        end
        // all four bytes must match in order
        chip_ok <= ((byte_cnt == 3'h0) | chip_ok) & (next_byte == chip_byte(byte_cnt));   // see (R14)
      end
    end
  end

  // address decoding; three lowest page bits never reach the block number
  assign blk_num = block_field(addr_q, binary_mode_in);   // see (R2) see (R3) see (R4)
  // sector number is the top six bits of the block field, any lower bits accepted
  assign sec_num = blk_num[BLOCK_BITS-1 -: SECTOR_BITS];   // see (R8) see (R10) see (R12) see (R13)
  // inside sector 0, page bit 3 (or logical bit 12) picks 0b over 0a
  assign sub_b   = (sec_num == 6'h00) & blk_num[0];   // see (R9) see (R11)

  // a command is whole only with four bytes on a byte boundary
  assign frame_whole = (byte_cnt == FRAME_BYTES) & (bit_cnt == 3'h0);
  assign start_kind  = !frame_whole                 ? KIND_NONE :
                       (opcode == OP_BLOCK_ERASE)  ? KIND_BLOCK :
                       (opcode == OP_SECTOR_ERASE) ? KIND_SECTOR :
                       chip_ok                      ? KIND_CHIP : KIND_NONE;
  // commands arriving while busy are ignored
  assign go = cs_rise & (state == ST_IDLE) & (start_kind != KIND_NONE);   // see (R5) see (R13) see (R16)
  assign chip_busy = (state == ST_ERASE) & (kind_q == KIND_CHIP);

  // self-timed erase sequencer
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= ST_IDLE;
      timer <= 32'h00000000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (go) begin
            state <= ST_ERASE;
            timer <= erase_len(start_kind);
          end
        end
        ST_ERASE: begin
          // back to ready whatever the error flag says
          if (timer == 32'h00000000) begin
            state <= ST_IDLE;   // see (R20)
          end else begin
            timer <= timer - 32'h00000001;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // error flag: cleared when a new erase starts, set by any failure while busy
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      erase_err <= 1'b0;
    end else if (go) begin
      erase_err <= 1'b0;
    end else if ((state == ST_ERASE) && erase_fail_in) begin
      erase_err <= 1'b1;   // see (R7)
    end
  end

  // erase command latched for the array
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      erase_start_out       <= 1'b0;
      kind_q                <= KIND_NONE;
      erase_block_out       <= 10'h000;
      erase_sector_out      <= 6'h00;
      erase_sub_b_out       <= 1'b0;
      erase_sector_mask_out <= 64'h0000000000000000;
    end else begin
      erase_start_out <= go;
      if (go) begin
        kind_q           <= start_kind;
        erase_block_out  <= blk_num;   // see (R1)
        erase_sector_out <= sec_num;
        erase_sub_b_out  <= sub_b;
        // chip erase only touches sectors neither protected nor locked
        erase_sector_mask_out <= (start_kind == KIND_CHIP) ?
                                 ~(sector_protect_in | sector_lock_in) : 64'h0000000000000000;   // see (R17)
      end
    end
  end

  // hardware protection follows the pin except during a chip erase
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hw_protect_out <= 1'b0;
    end else if (!chip_busy) begin
      hw_protect_out <= filt[3];   // see (R18)
    end
  end

  // busy whenever the sequencer runs
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ready_out <= 1'b1;
    end else begin
      ready_out <= ~go & ((state == ST_IDLE) | (timer == 32'h00000000));   // see (R6) see (R20)
    end
  end

  assign link.ready                   = ready_out;
  assign erase_kind_out               = kind_q;
  assign erase_program_error_flag_out = erase_err;
  assign erased_fill_out              = ERASED_BYTE;   // see (R19)

endmodule

// ---- src/flash_erase_pkg.sv ----
package flash_erase_pkg;

  // command bytes
  localparam logic [7:0] OP_BLOCK_ERASE  = 8'h50;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h7C;
  localparam logic [7:0] CHIP_SEQ_0      = 8'hC7;
  localparam logic [7:0] CHIP_SEQ_1      = 8'h94;
  localparam logic [7:0] CHIP_SEQ_2      = 8'h80;
  localparam logic [7:0] CHIP_SEQ_3      = 8'h9A;

  // frame shape: opcode plus three address bytes, or four chip erase bytes
  localparam logic [2:0] FRAME_BYTES = 3'h4;
  localparam int         FRAME_BITS  = 32;

  // address field positions inside the 24 address bits
  localparam int STD_BLOCK_LSB  = 13;   // page bits 12..3 at [22:13]
  localparam int BIN_BLOCK_LSB  = 12;   // logical bits 21..12 at [21:12]
  localparam int STD_SECTOR_LSB = 17;   // page bits 12..7 at [22:17]
  localparam int BIN_SECTOR_LSB = 16;   // logical bits 21..16 at [21:16]
  localparam int BLOCK_BITS     = 10;
  localparam int SECTOR_BITS    = 6;
  localparam int SECTOR_COUNT   = 64;

  // erased array content
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // clock and erase times
  localparam int CLK_PERIOD_NS      = 100;
  localparam int BLOCK_ERASE_TIME_US  = 50000;
  localparam int SECTOR_ERASE_TIME_US = 1000000;
  localparam int CHIP_ERASE_TIME_US   = 60000000;
  localparam int BLOCK_ERASE_CYCLES   = BLOCK_ERASE_TIME_US * (1000 / CLK_PERIOD_NS);
  localparam int SECTOR_ERASE_CYCLES  = SECTOR_ERASE_TIME_US * (1000 / CLK_PERIOD_NS);
  localparam int CHIP_ERASE_CYCLES    = CHIP_ERASE_TIME_US * (1000 / CLK_PERIOD_NS);

  // host side link timing
  localparam logic [1:0] SCK_HALF_LAST  = 2'h3;   // half period of four clocks
  localparam logic [3:0] HOST_GAP_LAST  = 4'h7;   // half periods after deselect

  // synchroniser reset value: {write protect, sck, cs_n, si}
  localparam logic [3:0] SYNC_RST = 4'h2;

  typedef enum logic [1:0] {
    KIND_NONE,
    KIND_BLOCK,
    KIND_SECTOR,
    KIND_CHIP
  } erase_kind_t;

endpackage

// ---- src/flash_link_if.sv ----
interface flash_link_if;
  logic sck;
  logic cs_n;
  logic si;
  logic ready;

  modport device (input sck, input cs_n, input si, output ready);
  modport host (output sck, output cs_n, output si, input ready);
endinterface

// ---- src/flash_erase_host.sv ----
module flash_erase_host (
  // clock and reset
  input  wire logic                        mclk_in,
  input  wire logic                        sys_rst_in,
  // serial link
  flash_link_if.host                       link,
  // command request
  input  wire logic                        cmd_valid_in,
  output logic                             cmd_ready_out,
  input  wire flash_erase_pkg::erase_kind_t cmd_kind_in,
  input  wire logic                        binary_mode_in,
  input  wire logic [9:0]                  cmd_block_in,
  input  wire logic [5:0]                  cmd_sector_in,
  input  wire logic                        cmd_sub_b_in,
  // status
  output logic                             device_ready_out
);
  import flash_erase_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE,
    H_SELECT,
    H_SHIFT,
    H_DESELECT,
    H_GAP
  } host_state_t;

  host_state_t state;
  logic [1:0]  div_cnt;
  logic        tick;
  logic [2:0]  rdy_sync;
  logic        rdy_filt;
  logic [31:0] frame;
  logic [31:0] frame_q;
  logic [4:0]  bit_idx;
  logic [3:0]  gap_cnt;
  logic        sck_q;
  logic        cs_n_q;
  logic        si_q;
  logic [23:0] blk_addr;
  logic [23:0] sec_addr;
  logic [9:0]  sec0_blk;
  logic        take;

  // sck half-period enable from the system clock
  assign tick = (div_cnt == SCK_HALF_LAST);
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      div_cnt <= 2'h0;
    end else begin
      div_cnt <= div_cnt + 2'h1;
    end
  end

  // device ready pin crosses in through three flops
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdy_sync <= 3'h0;
      rdy_filt <= 1'b0;
    end else begin
      rdy_sync <= {rdy_sync[1:0], link.ready};
      if (rdy_sync[1] == rdy_sync[2]) begin
        rdy_filt <= rdy_sync[2];
      end
    end
  end

  // address layouts per page mode
  assign blk_addr = binary_mode_in ? {2'b00, cmd_block_in, 12'h000} : {1'b0, cmd_block_in, 13'h0000};   // see (R2) see (R3)
  assign sec0_blk = {9'h000, cmd_sub_b_in};
  assign sec_addr = (cmd_sector_in == 6'h00) ?
                    (binary_mode_in ? {2'b00, sec0_blk, 12'h000} : {1'b0, sec0_blk, 13'h0000}) :   // see (R9) see (R11)
                    (binary_mode_in ? {2'b00, cmd_sector_in, 16'h0000} : {1'b0, cmd_sector_in, 17'h00000});   // see (R10) see (R12)
  assign frame = (cmd_kind_in == KIND_BLOCK)  ? {OP_BLOCK_ERASE, blk_addr} :
                 (cmd_kind_in == KIND_SECTOR) ? {OP_SECTOR_ERASE, sec_addr} :
                 {CHIP_SEQ_0, CHIP_SEQ_1, CHIP_SEQ_2, CHIP_SEQ_3};   // see (R14)

  // only one command at a time, and only once the device shows ready
  assign cmd_ready_out    = (state == H_IDLE) & rdy_filt & (cmd_kind_in != KIND_NONE);   // see (R21)
  assign take             = cmd_valid_in & cmd_ready_out;
  assign device_ready_out = rdy_filt;

  // frame sequencer: mode 0, data changes while sck is low
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state   <= H_IDLE;
      frame_q <= 32'h00000000;
      bit_idx <= 5'h00;
      gap_cnt <= 4'h0;
      sck_q   <= 1'b0;
      cs_n_q  <= 1'b1;
      si_q    <= 1'b0;
    end else begin
      case (state)
        H_IDLE: begin
          if (take) begin
            state   <= H_SELECT;
            frame_q <= frame;
            si_q    <= frame[FRAME_BITS-1];
            bit_idx <= 5'h00;
            cs_n_q  <= 1'b0;
          end
        end
        H_SELECT: begin
          if (tick) begin
            state <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (tick) begin
            if (!sck_q) begin
              sck_q <= 1'b1;
            end else begin
              sck_q   <= 1'b0;
              frame_q <= {frame_q[30:0], 1'b0};
              si_q    <= frame_q[30];
              bit_idx <= bit_idx + 5'h01;
              if (bit_idx == 5'(FRAME_BITS - 1)) begin
                state <= H_DESELECT;
              end
            end
          end
        end
        H_DESELECT: begin
          // raising chip select after the last bit launches the erase
          if (tick) begin
            cs_n_q  <= 1'b1;   // see (R16)
            si_q    <= 1'b0;
            gap_cnt <= 4'h0;
            state   <= H_GAP;
          end
        end
        H_GAP: begin
          // give the device time to drop ready before polling it again
          if (tick) begin
            gap_cnt <= gap_cnt + 4'h1;
            if (gap_cnt == HOST_GAP_LAST) begin
              state <= H_IDLE;   // see (R21)
            end
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end

  assign link.sck  = sck_q;
  assign link.cs_n = cs_n_q;
  assign link.si   = si_q;

endmodule

// ---- dv/flash_link_properties.sv ----
module flash_link_properties (
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // link signals
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       sck_q;
  logic [5:0] rise_count;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  // serial clock rises per frame, cleared while deselected
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sck_q <= 1'b0;
      rise_count <= 6'h00;
    end else begin
      sck_q <= sck;
      rise_count <= cs_n ? 6'h00 : rise_count + {5'h00, sck & ~sck_q};
    end
  end

  a_sck_idle_low: assert property (cs_n |-> !sck)
    else $error("serial clock moved while deselected");
  a_sck_half_period: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
    else $error("serial clock high phase not four clocks");
  a_si_held_high: assert property (sck |-> $stable(si))
    else $error("data changed while serial clock high");
  a_select_before_clock: assert property ($fell(cs_n) |-> !sck [*3])
    else $error("serial clock too soon after select");
  a_frame_bit_count: assert property ($rose(cs_n) |-> rise_count == 6'h20)
    else $error("frame did not hold thirty-two bits");
  a_start_after_frame: assert property ($rose(cs_n) && ready |-> ##[2:10] !ready)
    else $error("erase did not start after deselect");
  a_no_frame_busy: assert property (!ready |-> cs_n)
    else $error("frame sent while busy");
  a_busy_minimum: assert property ($fell(ready) |-> !ready [*8])
    else $error("busy flag too short");
  a_ready_returns: assert property ($fell(ready) |-> ##[1:1000] ready)
    else $error("busy flag never returned to ready");
endmodule

// ---- dv/serial_flash_erase_commands_tb.sv ----
module serial_flash_erase_commands_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import flash_erase_pkg::*;

  // erase counts shortened for simulation; the real times would run for hours
  localparam int BLK_N  = 200;
  localparam int SEC_N  = 300;
  localparam int CHIP_N = 400;

  logic        mclk_in, sys_rst_in, cmd_valid, cmd_ready, dev_ready, bin_mode, cmd_sub_b;
  erase_kind_t cmd_kind, kind_o, kind2;
  logic [9:0]  cmd_block, blk_o, blk2;
  logic [5:0]  cmd_sector, sec_o, sec2;
  logic [63:0] prot, lock, mask_o;
  logic        wp, fail, rdy, err, hwp, start, subb_o, start2, rdy2, err2, subb2;
  logic [7:0]  fill_o;
  logic [31:0] wire_bits;
  int          bad_count, total_checks, starts2;

  flash_link_if link();
  flash_link_if link2();

  flash_erase_host flash_erase_host_inst (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .link(link),
    .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .cmd_kind_in(cmd_kind), .binary_mode_in(bin_mode),
    .cmd_block_in(cmd_block), .cmd_sector_in(cmd_sector), .cmd_sub_b_in(cmd_sub_b), .device_ready_out(dev_ready));
  flash_erase_device #(.BLOCK_CYCLES(BLK_N), .SECTOR_CYCLES(SEC_N), .CHIP_CYCLES(CHIP_N)) flash_erase_device_inst (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .link(link), .binary_mode_in(bin_mode),
    .sector_protect_in(prot), .sector_lock_in(lock), .write_protect_in(wp), .erase_fail_in(fail),
    .ready_out(rdy), .erase_program_error_flag_out(err), .hw_protect_out(hwp), .erase_start_out(start),
    .erase_kind_out(kind_o), .erase_block_out(blk_o), .erase_sector_out(sec_o), .erase_sub_b_out(subb_o),
    .erase_sector_mask_out(mask_o), .erased_fill_out(fill_o));
  // second device faces a bench driver that breaks framing on purpose
  flash_erase_device #(.BLOCK_CYCLES(BLK_N), .SECTOR_CYCLES(SEC_N), .CHIP_CYCLES(CHIP_N)) flash_erase_device_inst2 (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .link(link2), .binary_mode_in(bin_mode),
    .sector_protect_in(prot), .sector_lock_in(lock), .write_protect_in(wp), .erase_fail_in(fail),
    .ready_out(rdy2), .erase_program_error_flag_out(err2), .hw_protect_out(), .erase_start_out(start2),
    .erase_kind_out(kind2), .erase_block_out(blk2), .erase_sector_out(sec2), .erase_sub_b_out(subb2),
    .erase_sector_mask_out(), .erased_fill_out());
  flash_link_properties flash_link_properties_inst (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .sck(link.sck), .cs_n(link.cs_n), .si(link.si), .ready(link.ready));

  // clock and watchdog; the watchdog span is several times the expected run
  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end
  initial begin
    repeat (60000) @(posedge mclk_in);
    bad_count++;
    complete_run;
  end

  // wire capture on the first link, start counting on the second link
  always @(posedge link.sck) if (!link.cs_n) wire_bits <= {wire_bits[30:0], link.si};
  always @(posedge mclk_in) if (start2 === 1'b1) starts2++;

  task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic check_count(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      bad_count++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // expected frame value in the upper half, meaningful bits in the lower half
  function automatic logic [63:0] frame_exp(input erase_kind_t k, input logic b, input logic [9:0] bk,
                                            input logic [5:0] sc, input logic sb);
    logic [31:0] v;
    logic [31:0] m;
    int          lo;
    v = 32'h0000_0000;
    m = 32'hFF00_0000;
    lo = b ? 12 : 13;
    v[31:24] = (k == KIND_BLOCK) ? 8'h50 : 8'h7C;
    if (k == KIND_CHIP) begin
      v = 32'hC794_809A;
      m = 32'hFFFF_FFFF;
    end else if (k == KIND_BLOCK || sc == 6'h00) begin
      v[lo +: 10] = (k == KIND_BLOCK) ? bk : {9'h000, sb};
      m[lo +: 10] = 10'h3FF;
    end else begin
      v[lo + 4 +: 6] = sc;
      m[lo + 4 +: 6] = 6'h3F;
    end
    return {v, m};
  endfunction

  // one erase through the host, checked on the wire and at the device
  task automatic send_cmd(input erase_kind_t k, input logic b, input logic [9:0] bk,
                          input logic [5:0] sc, input logic sb, input logic f);
    int          n;
    logic [63:0] fe;
    logic        seen;
    @(negedge mclk_in);
    cmd_kind = k;
    {bin_mode, cmd_block, cmd_sector, cmd_sub_b} = {b, bk, sc, sb};
    cmd_valid = 1'b1;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 2000) begin
      @(negedge mclk_in);
      n++;
    end
    @(negedge mclk_in);
    cmd_valid = 1'b0;
    while (start !== 1'b1 && n < 3000) begin
      @(negedge mclk_in);
      n++;
    end
    fe = frame_exp(k, b, bk, sc, sb);
    check_val(wire_bits & fe[31:0], fe[63:32] & fe[31:0]);
    check_val(kind_o, k);
    if (k == KIND_BLOCK) check_val(blk_o, bk);
    if (k == KIND_SECTOR) check_val({sec_o, subb_o}, {sc, sc == 6'h00 && sb});
    check_val(mask_o, (k == KIND_CHIP) ? ~(prot | lock) : 64'h0);
    check_val(fill_o, 8'hFF);
    wp = (k == KIND_CHIP);
    n = 0;
    seen = 1'b0;
    while (rdy === 1'b0 && n < 1000) begin
      seen = seen | hwp;
      if (n == 20) check_val(dev_ready, 1'b0);
      @(negedge mclk_in);
      fail = f && (n == 5);
      n++;
    end
    check_count(n, (k == KIND_BLOCK) ? BLK_N : (k == KIND_SECTOR) ? SEC_N : CHIP_N);
    check_val(err, f);
    if (k == KIND_CHIP) begin
      check_val(seen, 1'b0);
      repeat (8) @(negedge mclk_in);
      check_val(hwp, 1'b1);
      wp = 1'b0;
    end
  endtask

  // raw frame on the second link, left aligned, at an 800 ns serial period
  task automatic raw_frame(input logic [39:0] bits, input int n);
    @(negedge mclk_in);
    link2.cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      link2.si = bits[39 - i];
      repeat (4) @(negedge mclk_in);
      link2.sck = 1'b1;
      repeat (4) @(negedge mclk_in);
      link2.sck = 1'b0;
    end
    repeat (4) @(negedge mclk_in);
    link2.cs_n = 1'b1;
    link2.si = ~link2.si;
    repeat (20) @(negedge mclk_in);
  endtask

  task automatic wait_ready2;
    for (int i = 0; i < 1000 && rdy2 !== 1'b1; i++) @(negedge mclk_in);
    check_val(rdy2, 1'b1);
    check_val(err2, 1'b0);
  endtask

  // main sequence
  initial begin
    logic [9:0] v;
    logic [5:0] s;
    int         c;
    sys_rst_in = 1'b1;
    cmd_kind = KIND_NONE;
    {cmd_valid, bin_mode, cmd_block, cmd_sector, cmd_sub_b} = '0;
    {prot, lock, wp, fail, bad_count, total_checks} = '0;
    {link2.sck, link2.cs_n, link2.si} = 3'h2;
    void'($urandom(44));
    repeat (20) @(negedge mclk_in);
    sys_rst_in = 1'b0;
    repeat (5) @(negedge mclk_in);
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : 10'($urandom);
      send_cmd(KIND_BLOCK, i[0], v, 6'h00, 1'b0, i == 2);
    end
    $display("test block done");
    for (int i = 0; i < 8; i++) begin
      s = (i < 4) ? 6'h00 : (i == 4) ? 6'h01 : (i == 5) ? 6'h3F : 6'($urandom_range(1, 63));
      send_cmd(KIND_SECTOR, i[1] ^ i[2], 10'h000, s, i[0], 1'b0);
    end
    $display("test sector done");
    for (int i = 0; i < 2; i++) begin
      prot = {$urandom, $urandom};
      lock = {$urandom, $urandom};
      send_cmd(KIND_CHIP, i[0], 10'h000, 6'h00, 1'b0, i == 0);
    end
    $display("test chip done");
    bin_mode = 1'b0;
    v = 10'($urandom);
    s = 6'($urandom_range(1, 63));
    c = starts2;
    raw_frame({32'hC794_809B, 8'h00}, 32);
    check_count(starts2 - c, 0);
    raw_frame({24'hC7_9480, 16'h0000}, 24);
    check_count(starts2 - c, 0);
    raw_frame({32'hC794_809A, 8'hA5}, 40);
    check_count(starts2 - c, 1);
    check_val(kind2, KIND_CHIP);
    raw_frame({8'h50, 1'b1, v, 13'h1FFF, 8'h00}, 32);
    check_count(starts2 - c, 1);
    wait_ready2;
    raw_frame({8'h50, 1'b1, v, 13'h1FFF, 8'h00}, 32);
    check_val(blk2, v);
    wait_ready2;
    raw_frame({8'h7C, 1'b1, s, 17'h1A5A5, 8'h00}, 32);
    check_val(sec2, s);
    check_val(subb2, 1'b0);
    wait_ready2;
    $display("test raw link done");
    complete_run;
  end
endmodule
